// ===== ipf_issue_ctl.v
/*
  Issue control and per-period sequencing for unpack, pack, the delivery
  of normalize results, and floating sum and difference in single and
  double precision. Keeps busy flags of the operand and index registers,
  reservations of their input paths, the unit go flags and the delivery
  strobes; software sees state and an enable over an AHB-Lite slave.
  Assumes the issue stage presents one decoded instruction per period,
  synchronous to mclk_in, and holds it until issue_out is seen high.
*/
// Our own choices: the AHB-Lite slave port and the register offsets.
// Notes on behaviour
// - Unpack waits for free registers and paths.
// - Unpack delivers both results one period later.
// - Unpack issue advances parcel, feeds logical unit.
// - Period one: deliver, set busy and go.
// - Period two: clear busy and go flags.
// - Normalize delivers period two, clears busy later.
// - Pack waits for registers, operand path only.
// - Pack sends operands, delivers, go clears after.
// - Float add waits: registers, path three ahead.
// - Float add result fixed three periods later.
// - Float add issue sends both operands.
// - Period one: exponent difference, busy, go.
// - Period two: finish alignment, clear go.
// - Double precision applies exponent correction.
// - Period three: complete sum, write result.
// - Period four: clear destination busy flag.
// - Odd opcodes subtract, even opcodes add.
// - No execution delay once issued.
// - Issue moves next instruction into parcel.
`timescale 1ns/100ps
`include "ipf_issue_map.vh"
`default_nettype none

module ipf_issue_ctl #(
  parameter NREG = 8
) (
  input wire mclk_in,
  input wire rst_n_in,
  // Issue stage.
  input wire instr_valid_in,
  input wire [5:0] opcode_in,
  input wire [2:0] dest_sel_in,
  input wire [2:0] src_j_sel_in,
  input wire [2:0] src_k_sel_in,
  input wire issue_backup_path_in,
  output wire issue_out,
  output wire parcel_advance_out,
  output wire lu_send_src_out,
  output wire lu_send_index_out,
  output wire nz_send_src_out,
  output wire fa_send_src_out,
  // Register files and units.
  output reg [NREG-1:0] x_busy_out,
  output reg [NREG-1:0] b_busy_out,
  output reg lu_go_out,
  output reg nz_go_out,
  output reg fa_go_out,
  output reg lu_unpack_out,
  output reg fa_align_start_out,
  output reg fa_align_done_out,
  output reg fa_dp_correct_out,
  output reg fa_complete_out,
  output reg fa_subtract_out,
  output reg x_write_out,
  output reg [2:0] x_write_sel_out,
  output reg [1:0] x_write_src_out,
  output reg b_write_out,
  output reg [2:0] b_write_sel_out,
  output reg [1:0] b_write_src_out,
  // AHB-Lite slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata
);

  // Pipeline stages: suffix 1, 2, 3 is the period after issue.
  reg nz1_v_r;
  reg nz2_v_r;
  reg [2:0] nz1_i_r;
  reg [2:0] nz1_j_r;
  reg fa2_v_r;
  reg fa3_v_r;
  reg [2:0] fa1_i_r;
  reg [2:0] fa2_i_r;
  reg [2:0] fa3_i_r;
  reg fa1_dp_r;
  reg [2:0] lu1_i_r;
  reg [2:0] lu1_j_r;
  // Input path reservations; bit n means busy n+1 periods from now.
  reg [2:0] xpath_r;
  reg [2:0] bpath_r;
  reg [2:0] xpath_nxt;
  reg [2:0] bpath_nxt;
  reg [NREG-1:0] x_busy_nxt;
  reg [NREG-1:0] b_busy_nxt;
  reg ctrl_en_r;
  reg [31:0] count_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;

  wire is_nz;
  wire is_unp;
  wire is_pack;
  wire is_fa;
  wire x_i_free;
  wire x_j_free;
  wire x_k_free;
  wire b_j_free;
  wire ok_unp;
  wire ok_pack;
  wire ok_nz;
  wire ok_fa;
  wire bus_take;

  // Decode of the instruction in the upper parcel.
  assign is_nz = (opcode_in == `IPF_OP_NORMALIZER_UNIT) || (opcode_in == `IPF_OP_RNORM);
  assign is_unp = (opcode_in == `IPF_OP_UNPACK);
  assign is_pack = (opcode_in == `IPF_OP_PACK);
  assign is_fa = (opcode_in == `IPF_OP_FSUM) || (opcode_in == `IPF_OP_FDIF)
    || (opcode_in == `IPF_OP_DSUM) || (opcode_in == `IPF_OP_DDIF);

  assign x_i_free = ~x_busy_out[dest_sel_in];
  assign x_j_free = ~x_busy_out[src_j_sel_in];
  assign x_k_free = ~x_busy_out[src_k_sel_in];
  assign b_j_free = ~b_busy_out[src_j_sel_in];

  // Issue conditions per class; the backup path blocks every class.
  assign ok_unp = is_unp & x_i_free & x_k_free & b_j_free
    & ~xpath_r[0] & ~bpath_r[0];
  assign ok_pack = is_pack & x_i_free & x_k_free & b_j_free
    & ~xpath_r[0];
  assign ok_nz = is_nz & x_i_free & x_k_free & b_j_free
    & ~xpath_r[1] & ~bpath_r[1];
  assign ok_fa = is_fa & x_i_free & x_j_free & x_k_free
    & ~xpath_r[2];

  // Issue is gated by the software enable; unknown opcodes never issue.
  assign issue_out = instr_valid_in & ctrl_en_r & ~issue_backup_path_in
    & (ok_unp | ok_pack | ok_nz | ok_fa);
  assign parcel_advance_out = issue_out;
  assign lu_send_src_out = issue_out & (is_unp | is_pack);
  assign lu_send_index_out = issue_out & is_pack;
  assign nz_send_src_out = issue_out & is_nz;
  assign fa_send_src_out = issue_out & is_fa;

  // Path reservations shift toward now; a new normalize or float add issue books its delivery.
  always @*
  begin
    xpath_nxt = {1'b0, xpath_r[2:1]};
    bpath_nxt = {1'b0, bpath_r[2:1]};
    if (issue_out & is_nz)
    begin
      xpath_nxt[`IPF_LAT_NZ - 2] = 1'b1;
      bpath_nxt[`IPF_LAT_NZ - 2] = 1'b1;
    end
    if (issue_out & is_fa)
    begin
      xpath_nxt[`IPF_LAT_FA - 2] = 1'b1;
    end
  end

  // Busy flags: clears of finishing work first, so a new set wins.
  always @*
  begin
    x_busy_nxt = x_busy_out;
    b_busy_nxt = b_busy_out;
    if (lu_go_out)
    begin
      x_busy_nxt[lu1_i_r] = 1'b0;
      if (lu_unpack_out)
      begin
        b_busy_nxt[lu1_j_r] = 1'b0;
      end
    end
    if (nz2_v_r)
    begin
      x_busy_nxt[x_write_sel_out] = 1'b0;
      b_busy_nxt[b_write_sel_out] = 1'b0;
    end
    if (fa3_v_r)
    begin
      x_busy_nxt[fa3_i_r] = 1'b0;
    end
    if (issue_out)
    begin
      x_busy_nxt[dest_sel_in] = 1'b1;
      if (is_unp | is_nz)
      begin
        b_busy_nxt[src_j_sel_in] = 1'b1;
      end
    end
  end

  // Sequencing of every in-flight instruction; stages advance each
  // period unconditionally, so nothing issued can ever be delayed.
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      x_busy_out <= {NREG{1'b0}};
      b_busy_out <= {NREG{1'b0}};
      xpath_r <= 3'h0;
      bpath_r <= 3'h0;
      lu_go_out <= 1'b0;
      lu_unpack_out <= 1'b0;
      lu1_i_r <= 3'h0;
      lu1_j_r <= 3'h0;
      nz1_v_r <= 1'b0;
      nz2_v_r <= 1'b0;
      nz1_i_r <= 3'h0;
      nz1_j_r <= 3'h0;
      nz_go_out <= 1'b0;
      fa_go_out <= 1'b0;
      fa2_v_r <= 1'b0;
      fa3_v_r <= 1'b0;
      fa1_i_r <= 3'h0;
      fa2_i_r <= 3'h0;
      fa3_i_r <= 3'h0;
      fa1_dp_r <= 1'b0;
      fa_align_start_out <= 1'b0;
      fa_align_done_out <= 1'b0;
      fa_dp_correct_out <= 1'b0;
      fa_complete_out <= 1'b0;
      fa_subtract_out <= 1'b0;
      x_write_out <= 1'b0;
      x_write_sel_out <= 3'h0;
      x_write_src_out <= 2'h0;
      b_write_out <= 1'b0;
      b_write_sel_out <= 3'h0;
      b_write_src_out <= 2'h0;
    end
    else
    begin
      x_busy_out <= x_busy_nxt;
      b_busy_out <= b_busy_nxt;
      xpath_r <= xpath_nxt;
      bpath_r <= bpath_nxt;
      // Logical unit: one period, go flag high in that period only.
      lu_go_out <= issue_out & (is_unp | is_pack);
      if (issue_out & (is_unp | is_pack))
      begin
        lu_unpack_out <= is_unp;
        lu1_i_r <= dest_sel_in;
        lu1_j_r <= src_j_sel_in;
      end
      // Normalizer: go in period one, delivery in period two.
      nz1_v_r <= issue_out & is_nz;
      nz_go_out <= issue_out & is_nz;
      nz2_v_r <= nz1_v_r;
      if (issue_out & is_nz)
      begin
        nz1_i_r <= dest_sel_in;
        nz1_j_r <= src_j_sel_in;
      end
      // Floating add: fixed three-period pipeline for all operands.
      fa_go_out <= issue_out & is_fa;
      fa_align_start_out <= issue_out & is_fa;
      fa2_v_r <= fa_go_out;
      fa3_v_r <= fa2_v_r;
      fa_align_done_out <= fa_go_out;
      fa_dp_correct_out <= fa_go_out & fa1_dp_r;
      fa_complete_out <= fa2_v_r;
      fa2_i_r <= fa1_i_r;
      fa3_i_r <= fa2_i_r;
      if (issue_out & is_fa)
      begin
        fa1_i_r <= dest_sel_in;
        fa1_dp_r <= opcode_in[1]; // 32 and 33 are double precision.
        fa_subtract_out <= opcode_in[0];
      end
      // Operand register write strobes; path checks keep them unique.
      x_write_out <= (issue_out & (is_unp | is_pack)) | nz1_v_r | fa2_v_r;
      if (issue_out & (is_unp | is_pack))
      begin
        x_write_sel_out <= dest_sel_in;
        x_write_src_out <= `IPF_SRC_LU;
      end
      else if (nz1_v_r)
      begin
        x_write_sel_out <= nz1_i_r;
        x_write_src_out <= `IPF_SRC_NZ;
      end
      else if (fa2_v_r)
      begin
        x_write_sel_out <= fa2_i_r;
        x_write_src_out <= `IPF_SRC_FA;
      end
      // Index register write strobes.
      b_write_out <= (issue_out & is_unp) | nz1_v_r;
      if (issue_out & is_unp)
      begin
        b_write_sel_out <= src_j_sel_in;
        b_write_src_out <= `IPF_SRC_LU;
      end
      else if (nz1_v_r)
      begin
        b_write_sel_out <= nz1_j_r;
        b_write_src_out <= `IPF_SRC_NZ;
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY. Unmapped offsets
  // read zero and ignore writes, so a stray access cannot stop issue.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_take = hsel & htrans[1] & hready;

  // Read data is latched at the address phase so it stands from a flop.
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hrdata <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= bus_take & hwrite;
      wr_addr_r <= haddr[7:0];
      hrdata <= 32'h0000_0000;
      if (bus_take & ~hwrite)
      begin
        case (haddr[7:0])
          `IPF_REG_CTRL:
          begin
            hrdata[`IPF_CTRL_EN_BIT] <= ctrl_en_r;
          end
          `IPF_REG_STATUS:
          begin
            hrdata[`IPF_ST_XBUSY_LSB +: 8] <= x_busy_out[7:0];
            hrdata[`IPF_ST_BBUSY_LSB +: 8] <= b_busy_out[7:0];
            hrdata[`IPF_ST_LUGO_BIT] <= lu_go_out;
            hrdata[`IPF_ST_NZGO_BIT] <= nz_go_out;
            hrdata[`IPF_ST_FAGO_BIT] <= fa_go_out;
            hrdata[`IPF_ST_XPATH_LSB +: 3] <= xpath_r;
            hrdata[`IPF_ST_BPATH_LSB +: 3] <= bpath_r;
          end
          `IPF_REG_COUNT:
          begin
            hrdata <= count_r;
          end
          default:
          begin
            hrdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Control and issue counter; a clearing write in the same period as an
  // issue loads one, so no issue goes uncounted.
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_en_r <= 1'b1;
      count_r <= 32'h0000_0000;
    end
    else
    begin
      if (wr_pend_r & (wr_addr_r == `IPF_REG_CTRL))
      begin
        ctrl_en_r <= hwdata[`IPF_CTRL_EN_BIT];
      end
      if (wr_pend_r & (wr_addr_r == `IPF_REG_COUNT))
      begin
        count_r <= {31'h0000_0000, issue_out};
      end
      else if (issue_out)
      begin
        count_r <= count_r + 32'h0000_0001;
      end
    end
  end

endmodule // ipf_issue_ctl

`default_nettype wire

// ===== ipf_issue_ctl_assertions.sv
/* Checker for the issue control: issue gating and per-period sequencing.
   Assumes it is bound to ipf_issue_ctl, one clock, asynchronous reset. */
`timescale 1ns/100ps
`include "ipf_issue_map.vh"
`default_nettype none
module ipf_chk #(parameter NREG = 8) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [5:0] opcode_in,
  input wire logic [2:0] dest_sel_in,
  input wire logic issue_backup_path_in,
  input wire logic issue_out,
  input wire logic lu_send_index_out,
  input wire logic fa_send_src_out,
  input wire logic [NREG-1:0] x_busy_out,
  input wire logic lu_go_out,
  input wire logic fa_go_out,
  input wire logic fa_dp_correct_out,
  input wire logic x_write_out,
  input wire logic [1:0] x_write_src_out,
  input wire logic b_write_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // A lone issue is one with nothing of its unit issued right behind it.
  sequence s_unpk;
    issue_out && opcode_in == `IPF_OP_UNPACK;
  endsequence
  sequence s_fa_lone;
    fa_send_src_out ##1 !fa_send_src_out;
  endsequence
  AST_GATE: assert property (issue_out |-> !issue_backup_path_in)
    else $error("issue during backup");
  AST_UNPK: assert property (s_unpk |=> lu_go_out && x_write_out && b_write_out)
    else $error("unpack not delivered one period after issue");
  AST_UNPK_CLR: assert property (s_unpk ##1 !issue_out |=> !lu_go_out)
    else $error("logical go flag not cleared");
  AST_PACK: assert property (
    lu_send_index_out |=> ##1 !x_busy_out[$past(dest_sel_in, 2)])
    else $error("pack busy flag not cleared");
  AST_FA_DLV: assert property (
    fa_send_src_out |-> ##3 x_write_out && x_write_src_out == `IPF_SRC_FA)
    else $error("float add result not written at period three");
  AST_FA_GO: assert property (s_fa_lone |-> fa_go_out ##1 !fa_go_out)
    else $error("float add go flag wrong");
  AST_FA_DP: assert property (
    fa_send_src_out |-> ##2 fa_dp_correct_out == ($past(opcode_in, 2) >= `IPF_OP_DSUM))
    else $error("exponent correction wrong");
  AST_FA_CLR: assert property (fa_send_src_out |-> ##3
    x_busy_out[$past(dest_sel_in, 3)] ##1 !x_busy_out[$past(dest_sel_in, 4)])
    else $error("float add busy window wrong");
endmodule // ipf_chk
bind ipf_issue_ctl ipf_chk #(.NREG(NREG)) ipf_chk_inst (
  .mclk_in(mclk_in),
  .rst_n_in(rst_n_in),
  .opcode_in(opcode_in),
  .dest_sel_in(dest_sel_in),
  .issue_backup_path_in(issue_backup_path_in),
  .issue_out(issue_out),
  .lu_send_index_out(lu_send_index_out),
  .fa_send_src_out(fa_send_src_out),
  .x_busy_out(x_busy_out),
  .lu_go_out(lu_go_out),
  .fa_go_out(fa_go_out),
  .fa_dp_correct_out(fa_dp_correct_out),
  .x_write_out(x_write_out),
  .x_write_src_out(x_write_src_out),
  .b_write_out(b_write_out)
);
`default_nettype wire

// ===== ipf_issue_map.vh
/*
  Constants for the issue and sequencing control of the unpack, pack,
  normalize delivery and floating add instructions: opcodes, latencies,
  register offsets, field positions and reset values.
  Assumes 6-bit opcodes and 3-bit register designators.
*/
`ifndef IPF_ISSUE_MAP_VH
`define IPF_ISSUE_MAP_VH

// Opcodes, octal 24..27 and 30..33.
`define IPF_OP_NORMALIZER_UNIT 6'h14
`define IPF_OP_RNORM 6'h15
`define IPF_OP_UNPACK 6'h16
`define IPF_OP_PACK 6'h17
`define IPF_OP_FSUM 6'h18
`define IPF_OP_FDIF 6'h19
`define IPF_OP_DSUM 6'h1A
`define IPF_OP_DDIF 6'h1B

// Delivery latencies in clock periods after issue.
`define IPF_LAT_LU 1
`define IPF_LAT_NZ 2
`define IPF_LAT_FA 3

// Result source codes on the write strobes.
`define IPF_SRC_LU 2'h1
`define IPF_SRC_NZ 2'h2
`define IPF_SRC_FA 2'h3

// Register byte offsets.
`define IPF_REG_CTRL 8'h00
`define IPF_REG_STATUS 8'h04
`define IPF_REG_COUNT 8'h08

// Control register fields and reset value.
`define IPF_CTRL_EN_BIT 0
`define IPF_CTRL_RESET 32'h0000_0001

// Status register fields.
`define IPF_ST_XBUSY_LSB 0
`define IPF_ST_BBUSY_LSB 8
`define IPF_ST_LUGO_BIT 16
`define IPF_ST_NZGO_BIT 17
`define IPF_ST_FAGO_BIT 18
`define IPF_ST_XPATH_LSB 20
`define IPF_ST_BPATH_LSB 24

`endif

// ===== ipf_stage.sv
/* Issue stage model: holds one instruction in the upper parcel.
   Assumes the bench queues words {opcode, i, j, k}. */
`timescale 1ns/100ps
`default_nettype none
module ipf_stage (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic issue_in,
  output wire logic valid_out,
  output wire logic [14:0] word_out
);
  logic [14:0] q[$];
  logic valid_r = 1'b0;
  logic [14:0] word_r = 15'h0;
  assign valid_out = valid_r;
  assign word_out = word_r;
  // A refused parcel is held; an empty one shows a toggling pattern, not stale bits.
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      valid_r <= 1'b0;
    else if (issue_in || !valid_r)
    begin
      valid_r <= q.size() != 0;
      if (q.size() != 0)
        word_r <= q.pop_front();
      else
        word_r <= ~word_r;
    end
  end
endmodule // ipf_stage
`default_nettype wire

// ===== issue_timing_pack_float_add_bench.sv
/* Self-checking bench: one task a scenario, sampled at falling edges; bus read data at rising edges.
   Assumes ipf_stage as issue stage and the bound checker. */
`timescale 1ns/100ps
`include "ipf_issue_map.vh"
`default_nettype none
module issue_timing_pack_float_add_bench;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic issue_backup_path_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire [2:0] hsize = 3'h2;
  wire [14:0] word;
  wire [5:0] opcode_in;
  wire [2:0] dest_sel_in, src_j_sel_in, src_k_sel_in, x_write_sel_out, b_write_sel_out;
  wire [7:0] x_busy_out, b_busy_out;
  wire [1:0] x_write_src_out, b_write_src_out;
  wire [31:0] hrdata;
  wire instr_valid_in, issue_out, parcel_advance_out, lu_send_src_out, lu_send_index_out;
  wire nz_send_src_out, fa_send_src_out, lu_go_out, nz_go_out, fa_go_out, lu_unpack_out;
  wire fa_align_start_out, fa_align_done_out, fa_dp_correct_out, fa_complete_out;
  wire fa_subtract_out, x_write_out, b_write_out, hreadyout, hresp, hready;
  int compares = 0;
  int miscompares = 0;
  int ticks = 0;
  // One slave, so its ready is the bus ready; the parcel word feeds the designators.
  assign hready = hreadyout;
  assign {opcode_in, dest_sel_in, src_j_sel_in, src_k_sel_in} = word;
  ipf_issue_ctl ipf_issue_ctl_inst (.*);
  ipf_stage ipf_stage_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .issue_in(issue_out),
    .valid_out(instr_valid_in), .word_out(word));
  // Clock of 100 ns; a hang is cut short well beyond the run's length.
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    ticks <= ticks + 1;
    if (ticks == 3000)
    begin
      miscompares++;
      conclude;
    end
  end
  task automatic conclude;
  begin
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  end
  endtask
  // Queue one instruction and return at the falling edge of its issue period.
  task automatic run(input logic [5:0] op, input logic [8:0] ijk, output int n);
  begin
    n = 0;
    ipf_stage_inst.q.push_back({op, ijk});
    @(negedge mclk_in);
    while (issue_out !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge mclk_in);
    end
  end
  endtask
  // One single-word transfer; read data is taken at the edge ending the data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge mclk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge mclk_in);
    while (hready !== 1'b1)
      @(posedge mclk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk_in);
    while (hready !== 1'b1)
      @(posedge mclk_in);
    rd = hrdata;
    chk({hreadyout, hresp}, 2'h2);
    @(negedge mclk_in);
  end
  endtask
  task automatic t_unpack;
    int n;
  begin
    run(`IPF_OP_UNPACK, 9'o123, n);
    chk({n[3:0], parcel_advance_out, lu_send_src_out}, 6'h03);
    @(negedge mclk_in);
    chk({lu_go_out, x_busy_out[1], b_busy_out[2], x_write_out, b_write_out}, 5'h1F);
    chk({x_write_sel_out, b_write_sel_out, x_write_src_out}, {6'o12, `IPF_SRC_LU});
    @(negedge mclk_in);
    chk({lu_go_out, x_busy_out, b_busy_out}, 0);
  end
  endtask
  task automatic t_pack;
    int n;
  begin
    run(`IPF_OP_PACK, 9'o567, n);
    chk({n[3:0], lu_send_index_out}, 5'h01);
    @(negedge mclk_in);
    chk({lu_go_out, x_busy_out[5], x_write_out, lu_unpack_out}, 4'hE);
    @(negedge mclk_in);
    chk({lu_go_out, x_busy_out}, 0);
  end
  endtask
  // Plain and rounded normalize share the same delivery sequence.
  task automatic t_normalizer_unit;
    int n;
    logic [5:0] op;
  begin
    for (int o = 0; o < 2; o++)
    begin
      op = `IPF_OP_NORMALIZER_UNIT + 6'(o);
      run(op, 9'o234, n);
      chk({nz_send_src_out, lu_send_src_out, fa_send_src_out}, 3'h4);
      @(negedge mclk_in);
      chk({nz_go_out, x_busy_out[2], b_busy_out[3], x_write_out}, 4'hE);
      @(negedge mclk_in);
      chk({x_write_out, b_write_out, x_write_src_out, nz_go_out}, {2'h3, `IPF_SRC_NZ, 1'b0});
      chk({x_write_sel_out, b_write_sel_out, b_write_src_out}, {6'o23, `IPF_SRC_NZ});
      @(negedge mclk_in);
      chk({x_busy_out, b_busy_out}, 0);
    end
  end
  endtask
  task automatic t_fa;
    int n;
    logic [5:0] op;
  begin
    for (int o = 0; o < 4; o++)
    begin
      op = `IPF_OP_FSUM + 6'(o);
      run(op, 9'o456, n);
      chk(fa_send_src_out, 1);
      @(negedge mclk_in);
      chk({fa_go_out, fa_align_start_out, x_busy_out[4], fa_subtract_out}, {3'h7, op[0]});
      @(negedge mclk_in);
      chk({fa_go_out, fa_align_done_out, fa_dp_correct_out}, {2'h1, op[1]});
      @(negedge mclk_in);
      chk({fa_complete_out, x_write_out, x_busy_out[4], x_write_sel_out}, 6'o74);
      @(negedge mclk_in);
      chk(x_busy_out, 0);
    end
  end
  endtask
  task automatic t_hazard;
    int n;
  begin
    run(`IPF_OP_FSUM, 9'o123, n);
    run(`IPF_OP_FDIF, 9'o600, n);
    chk(n, 0);
    run(`IPF_OP_UNPACK, 9'o451, n);
    chk(n, 2);
    repeat (4) @(negedge mclk_in);
  end
  endtask
  task automatic t_backup;
  begin
    @(posedge mclk_in);
    issue_backup_path_in <= 1'b1;
    @(negedge mclk_in);
    ipf_stage_inst.q.push_back({`IPF_OP_PACK, 9'o123});
    repeat (3) @(negedge mclk_in);
    chk(issue_out, 0);
    @(posedge mclk_in);
    issue_backup_path_in <= 1'b0;
    @(negedge mclk_in);
    chk(issue_out, 1);
    repeat (2) @(negedge mclk_in);
  end
  endtask
  // Reset value, counter, unmapped place, issue held off by the enable, and
  // the status word in the period after the held pack finally issues.
  task automatic t_bus;
  begin
    bus(1'b0, `IPF_REG_CTRL, 0);
    chk(rd, `IPF_CTRL_RESET);
    bus(1'b0, `IPF_REG_COUNT, 0);
    chk(rd, 12);
    bus(1'b1, `IPF_REG_COUNT, 0);
    bus(1'b1, `IPF_REG_CTRL, 0);
    ipf_stage_inst.q.push_back({`IPF_OP_PACK, 9'o0});
    bus(1'b0, 8'h0C, 0);
    chk(rd, 0);
    bus(1'b0, `IPF_REG_COUNT, 0);
    chk(rd, 0);
    bus(1'b1, `IPF_REG_CTRL, 1);
    bus(1'b0, `IPF_REG_STATUS, 0);
    chk(rd, (32'h1 << `IPF_ST_LUGO_BIT) | (32'h1 << `IPF_ST_XBUSY_LSB));
    bus(1'b0, `IPF_REG_COUNT, 0);
    chk(rd, 1);
  end
  endtask
  initial
  begin
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
    t_unpack;
    t_pack;
    t_normalizer_unit;
    t_fa;
    t_hazard;
    t_backup;
    t_bus;
    conclude;
  end
endmodule // issue_timing_pack_float_add_bench
`default_nettype wire
